// [rtl/fsqs_map.svh]
// Purpose: Offsets, field positions, reset values and counts of the root/subtract unit.
// Assumes: Included by its bare name from the design file.
// Notes: Register offsets are Avalon word addresses.
`ifndef FSQS_MAP_SVH
`define FSQS_MAP_SVH
`define FSQS_PRI_DBL 6'h3f
`define FSQS_PRI_SGL 6'h3b
`define FSQS_XO_ROOT 5'h16
`define FSQS_XO_SUB 5'h14
`define FSQS_REG_A_LO 4'h0
`define FSQS_REG_A_HI 4'h1
`define FSQS_REG_B_LO 4'h2
`define FSQS_REG_B_HI 4'h3
`define FSQS_REG_INSN 4'h4
`define FSQS_REG_FSC 4'h5
`define FSQS_REG_RES_LO 4'h6
`define FSQS_REG_RES_HI 4'h7
`define FSQS_REG_STAT 4'h8
`define FSQS_ST_ILL 5
`define FSQS_FSC_RST 32'h0000_0000
`define FSQS_B_FX 31
`define FSQS_B_FEX 30
`define FSQS_B_VX 29
`define FSQS_B_OX 28
`define FSQS_B_UX 27
`define FSQS_B_XX 25
`define FSQS_B_SIGNALING_NAN_INVALID_FLAG 24
`define FSQS_B_INF_MINUS_INF_FLAG 23
`define FSQS_B_FR 18
`define FSQS_B_FI 17
`define FSQS_B_INVALID_ROOT_FLAG 9
`define FSQS_B_VE 7
`define FSQS_EXC_MASK 32'h1ff8_0700
`define FSQS_VX_MASK 32'h01f8_0700
`define FSQS_ROOT_LAST 6'h37
`define FSQS_BIAS 14'h03ff
`define FSQS_DBL_EMAX 14'h07fe
`define FSQS_SGL_EMIN 14'h0381
`define FSQS_SGL_EMAX 14'h047e
`define FSQS_QNAN 64'h7ff8_0000_0000_0000
`define FSQS_QBIT 64'h0008_0000_0000_0000
`define FSQS_SGL_DROP 64'h0000_0000_1fff_ffff
`define FSQS_CL_QNAN 5'h11
`define FSQS_CL_NINF 5'h09
`define FSQS_CL_NNRM 5'h08
`define FSQS_CL_NDEN 5'h18
`define FSQS_CL_NZER 5'h12
`define FSQS_CL_PZER 5'h02
`define FSQS_CL_PDEN 5'h14
`define FSQS_CL_PNRM 5'h04
`define FSQS_CL_PINF 5'h05
`endif

// [rtl/fsqs_pkg.sv]
// Purpose: Types of the root/subtract unit.
// Assumes: Nothing.
// Notes: None.
package fsqs_pkg;
  typedef enum logic [3:0] {
    FSQS_IDLE = 4'b0001,
    FSQS_PREP = 4'b0010,
    FSQS_ROOT = 4'b0100,
    FSQS_FIN = 4'b1000
  } fsqs_state_t;
  typedef struct packed {
    logic [63:0] val;
    logic ox;
    logic ux;
    logic xx;
    logic fr;
  } fsqs_rnd_t;
endpackage : fsqs_pkg

// [rtl/fsqs_unit.sv]
// Purpose: Root and subtract execution unit, double and single forms, Avalon-MM slave.
// Assumes: Operands of single forms are representable in single precision.
// Notes: Trap-enabled overflow and underflow exponent adjustment is not modelled.
`timescale 1ns/100ps
`include "fsqs_map.svh"
`default_nettype none
module fsqs_unit #(
  parameter bit HAS_ROOT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic op_done,
  output logic illegal_insn
);
  // ==========================================================================
  // Functions
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    logic hit;
    n = 7'h40;
    hit = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i] && !hit) begin
        n = 7'(63 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  function automatic logic [63:0] shr_sticky(input logic [63:0] v, input logic [6:0] sh);
    logic [63:0] r;
    if (sh >= 7'h40) begin
      r = {63'h0, v != 64'h0};
    end else begin
      r = v >> sh;
      r[0] = r[0] | ((v & ((64'h1 << sh) - 64'h1)) != 64'h0);
    end
    return r;
  endfunction : shr_sticky

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [4:0] result_class(input logic [63:0] v, input logic sgl);
    logic den;
    den = (v[62:52] == 11'h000) || (sgl && ({3'h0, v[62:52]} < `FSQS_SGL_EMIN));
    if (v[62:52] == 11'h7ff) begin
      if (v[51:0] != 52'h0) return `FSQS_CL_QNAN;
      return v[63] ? `FSQS_CL_NINF : `FSQS_CL_PINF;
    end
    if (v[62:0] == 63'h0) return v[63] ? `FSQS_CL_NZER : `FSQS_CL_PZER;
    if (v[63]) return den ? `FSQS_CL_NDEN : `FSQS_CL_NNRM;
    return den ? `FSQS_CL_PDEN : `FSQS_CL_PNRM;
  endfunction : result_class

  // Rounds m (msb at bit 63 weighs 2^(e-bias)) to 24 or 53 bits and packs a double.
  function automatic fsqs_pkg::fsqs_rnd_t round_pack(input logic s,
      input logic signed [13:0] e_in, input logic [63:0] m, input logic sgl,
      input logic [1:0] mode);
    fsqs_pkg::fsqs_rnd_t r;
    logic signed [13:0] e, emin, emax, d;
    logic [63:0] t, keep, rem, half, one;
    logic [53:0] k;
    logic [52:0] m53;
    logic [6:0] lz, cut;
    logic inc, tiny, up_inf;
    cut = sgl ? 7'h28 : 7'h0b;
    e = e_in;
    emin = sgl ? `FSQS_SGL_EMIN : 14'h0001;
    emax = sgl ? `FSQS_SGL_EMAX : `FSQS_DBL_EMAX;
    tiny = e < emin;
    d = emin - e;
    t = tiny ? shr_sticky(m, (d > 14'sh0040) ? 7'h40 : d[6:0]) : m;
    if (tiny) e = emin;
    keep = t >> cut;
    one = 64'h1 << cut;
    rem = t & (one - 64'h1);
    half = one >> 1;
    r.xx = rem != 64'h0;
    case (mode)
      2'h0: inc = (rem > half) || ((rem == half) && keep[0]);
      2'h1: inc = 1'b0;
      2'h2: inc = !s && r.xx;
      2'h3: inc = s && r.xx;
    endcase
    k = keep[53:0] + {53'h0, inc};
    if ((sgl && k[24]) || (!sgl && k[53])) begin
      k = k >> 1;
      e = e + 14'sh0001;
    end
    m53 = 53'(k << (cut - 7'h0b));
    r.fr = inc;
    r.ox = e > emax;
    r.ux = tiny && r.xx;
    up_inf = (mode == 2'h0) || ((mode == 2'h2) && !s) || ((mode == 2'h3) && s);
    if (r.ox) begin
      r.xx = 1'b1;
      r.fr = up_inf;
      m53 = ~53'h0 << (cut - 7'h0b);
      r.val = up_inf ? {s, 11'h7ff, 52'h0} : {s, emax[10:0], m53[51:0]};
    end else if (m53[52]) begin
      r.val = {s, e[10:0], m53[51:0]};
    end else if (!sgl || (m53 == 53'h0)) begin
      r.val = {s, 11'h000, m53[51:0]};
    end else begin
      lz = lead_zeros({m53, 11'h0});
      m53 = m53 << lz;
      e = e - $signed({7'h0, lz});
      r.val = {s, e[10:0], m53[51:0]};
    end
    return r;
  endfunction : round_pack

  // ==========================================================================
  // State and decode
  fsqs_pkg::fsqs_state_t st_q;
  logic [63:0] opa_q, opb_q, res_q, sval_q, sig_q;
  logic [31:0] insn_q, fsc_q, rd_d;
  logic [3:0] cond_q;
  logic wr_q, acc, wrote_q, ill_q, spec_q, snan_q, isi_q, sqinv_q, sgn_q;
  logic signed [13:0] exp_q;
  logic [111:0] rad_q;
  logic [59:0] rem_q;
  logic [55:0] root_q;
  logic [5:0] iter_q;
  logic op_sgl, op_root, op_sub, op_rc, op_valid, fin_go;
  logic [1:0] mode;

  assign op_sgl = insn_q[31:26] == `FSQS_PRI_SGL;
  assign op_root = insn_q[5:1] == `FSQS_XO_ROOT;
  assign op_sub = insn_q[5:1] == `FSQS_XO_SUB;
  assign op_rc = insn_q[0];
  assign op_valid = ((insn_q[31:26] == `FSQS_PRI_DBL) || op_sgl) &&
                    (op_sub || (op_root && HAS_ROOT));
  assign mode = fsc_q[1:0];
  assign fin_go = (st_q == fsqs_pkg::FSQS_FIN) && ce;
  assign acc = (avs_read || avs_write) && !wr_q;

  // ==========================================================================
  // Avalon slave
  always_comb begin
    case (avs_address)
      `FSQS_REG_A_LO: rd_d = opa_q[31:0];
      `FSQS_REG_A_HI: rd_d = opa_q[63:32];
      `FSQS_REG_B_LO: rd_d = opb_q[31:0];
      `FSQS_REG_B_HI: rd_d = opb_q[63:32];
      `FSQS_REG_INSN: rd_d = insn_q;
      `FSQS_REG_FSC: rd_d = fsc_q;
      `FSQS_REG_RES_LO: rd_d = res_q[31:0];
      `FSQS_REG_RES_HI: rd_d = res_q[63:32];
      `FSQS_REG_STAT: rd_d = {26'h0, ill_q, wrote_q, cond_q};
      default: rd_d = 32'h0;
    endcase
  end

  // Accesses are held off while an operation runs, so software never races the unit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (ce) begin
      wr_q <= !((avs_read || avs_write) && wr_q && (st_q == fsqs_pkg::FSQS_IDLE));
      if ((avs_read || avs_write) && wr_q) begin
        avs_readdata <= avs_read ? rd_d : 32'h0;
      end
    end
  end
  assign avs_waitrequest = wr_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      opa_q <= 64'h0;
      opb_q <= 64'h0;
      insn_q <= 32'h0;
    end else if (ce && acc && avs_write) begin
      case (avs_address)
        `FSQS_REG_A_LO: opa_q[31:0] <= be_merge(opa_q[31:0], avs_writedata, avs_byteenable);
        `FSQS_REG_A_HI: opa_q[63:32] <= be_merge(opa_q[63:32], avs_writedata, avs_byteenable);
        `FSQS_REG_B_LO: opb_q[31:0] <= be_merge(opb_q[31:0], avs_writedata, avs_byteenable);
        `FSQS_REG_B_HI: opb_q[63:32] <= be_merge(opb_q[63:32], avs_writedata, avs_byteenable);
        `FSQS_REG_INSN: insn_q <= be_merge(insn_q, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Operand preparation
  logic p_spec, p_snan, p_isi, p_sqrt, p_sgn, sbx, a_nan, b_nan, a_inf, b_inf, a_big;
  logic [63:0] p_val, p_sig, raw, wa, wb, wbig, wsml;
  logic signed [13:0] p_exp, eu;
  logic [111:0] p_rad;
  logic [10:0] ea, eb, dexp;
  logic [6:0] lzp;

  assign a_nan = (opa_q[62:52] == 11'h7ff) && (opa_q[51:0] != 52'h0);
  assign b_nan = (opb_q[62:52] == 11'h7ff) && (opb_q[51:0] != 52'h0);
  assign a_inf = opa_q[62:0] == {11'h7ff, 52'h0};
  assign b_inf = opb_q[62:0] == {11'h7ff, 52'h0};
  assign ea = (opa_q[62:52] == 11'h000) ? 11'h001 : opa_q[62:52];
  assign eb = (opb_q[62:52] == 11'h000) ? 11'h001 : opb_q[62:52];
  assign sbx = opb_q[63] ^ op_sub;
  assign a_big = opa_q[62:0] >= opb_q[62:0];
  assign wa = {1'b0, opa_q[62:52] != 11'h000, opa_q[51:0], 10'h0};
  assign wb = {1'b0, opb_q[62:52] != 11'h000, opb_q[51:0], 10'h0};

  always_comb begin
    p_spec = 1'b0;
    p_val = 64'h0;
    p_snan = 1'b0;
    p_isi = 1'b0;
    p_sqrt = 1'b0;
    p_sgn = 1'b0;
    p_exp = 14'sh0000;
    p_sig = 64'h0;
    p_rad = 112'h0;
    raw = {opb_q[62:52] != 11'h000, opb_q[51:0], 11'h0};
    lzp = lead_zeros(raw);
    eu = $signed({3'h0, eb}) - $signed({7'h0, lzp}) - $signed(`FSQS_BIAS);
    wbig = a_big ? wa : wb;
    dexp = a_big ? (ea - eb) : (eb - ea);
    wsml = shr_sticky(a_big ? wb : wa, (dexp >= 11'h040) ? 7'h40 : dexp[6:0]);
    if (op_root) begin
      p_spec = 1'b1;
      if (b_nan) begin
        p_val = opb_q | `FSQS_QBIT;
        p_snan = !opb_q[51];
      end else if ((opb_q[62:0] == 63'h0) || (b_inf && !opb_q[63])) begin
        p_val = opb_q;
      end else if (opb_q[63]) begin
        p_val = `FSQS_QNAN;
        p_sqrt = 1'b1;
      end else begin
        p_spec = 1'b0;
        // The bias is kept signed so that the halving of a negative exponent stays arithmetic.
        p_exp = (eu >>> 1) + $signed(`FSQS_BIAS);
        p_rad = eu[0] ? {raw << lzp, 48'h0} : {1'b0, raw << lzp, 47'h0};
      end
    end else begin
      p_spec = 1'b1;
      if (a_nan || b_nan) begin
        p_val = (a_nan ? opa_q : opb_q) | `FSQS_QBIT;
        p_snan = (a_nan && !opa_q[51]) || (b_nan && !opb_q[51]);
      end else if (a_inf && b_inf && (opa_q[63] != sbx)) begin
        p_val = `FSQS_QNAN;
        p_isi = 1'b1;
      end else if (a_inf) begin
        p_val = opa_q;
      end else if (b_inf) begin
        p_val = {sbx, opb_q[62:0]};
      end else begin
        p_sig = (opa_q[63] == sbx) ? (wbig + wsml) : (wbig - wsml);
        p_sgn = a_big ? opa_q[63] : sbx;
        p_exp = $signed({3'h0, a_big ? ea : eb}) + 14'sh0001;
        p_spec = p_sig == 64'h0;
        p_val = {(opa_q[63] == sbx) ? opa_q[63] : (mode == 2'h3), 63'h0};
      end
    end
  end

  // ==========================================================================
  // Sequencer and root iteration
  logic [59:0] r2, trial, rm_n;
  logic [55:0] rt_n;
  assign r2 = {rem_q[57:0], rad_q[111:110]};
  assign trial = {2'h0, root_q, 2'h1};
  assign rm_n = (r2 >= trial) ? (r2 - trial) : r2;
  assign rt_n = {root_q[54:0], r2 >= trial};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= fsqs_pkg::FSQS_IDLE;
    end else if (ce) begin
      unique case (st_q)
        fsqs_pkg::FSQS_IDLE: begin
          if (acc && avs_write && (avs_address == `FSQS_REG_INSN)) st_q <= fsqs_pkg::FSQS_PREP;
        end
        fsqs_pkg::FSQS_PREP: begin
          if (!op_valid) st_q <= fsqs_pkg::FSQS_IDLE;
          else if (op_root && !p_spec) st_q <= fsqs_pkg::FSQS_ROOT;
          else st_q <= fsqs_pkg::FSQS_FIN;
        end
        fsqs_pkg::FSQS_ROOT: begin
          if (iter_q == `FSQS_ROOT_LAST) st_q <= fsqs_pkg::FSQS_FIN;
        end
        fsqs_pkg::FSQS_FIN: st_q <= fsqs_pkg::FSQS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {spec_q, snan_q, isi_q, sqinv_q, sgn_q} <= 5'h00;
      sval_q <= 64'h0;
      sig_q <= 64'h0;
      exp_q <= 14'sh0000;
      rad_q <= 112'h0;
      rem_q <= 60'h0;
      root_q <= 56'h0;
      iter_q <= 6'h00;
    end else if (ce && (st_q == fsqs_pkg::FSQS_PREP)) begin
      {spec_q, snan_q, isi_q, sqinv_q, sgn_q} <= {p_spec, p_snan, p_isi, p_sqrt, p_sgn};
      sval_q <= p_val;
      sig_q <= p_sig;
      exp_q <= p_exp;
      rad_q <= p_rad;
      rem_q <= 60'h0;
      root_q <= 56'h0;
      iter_q <= 6'h00;
    end else if (ce && (st_q == fsqs_pkg::FSQS_ROOT)) begin
      rad_q <= rad_q << 2;
      rem_q <= rm_n;
      root_q <= rt_n;
      iter_q <= iter_q + 6'h01;
      if (iter_q == `FSQS_ROOT_LAST) sig_q <= {rt_n, 7'h0, rm_n != 60'h0};
    end
  end

  // ==========================================================================
  // Normalize, round and commit
  fsqs_pkg::fsqs_rnd_t rr;
  logic [6:0] lzf;
  logic [63:0] fin_val;
  logic [31:0] nf;
  logic supp;
  assign lzf = lead_zeros(sig_q);
  assign rr = round_pack(sgn_q, exp_q - $signed({7'h0, lzf}), sig_q << lzf,
                         op_sgl, mode);
  assign fin_val = !spec_q ? rr.val : (op_sgl ? (sval_q & ~`FSQS_SGL_DROP) : sval_q);
  assign supp = (snan_q || isi_q || sqinv_q) && fsc_q[`FSQS_B_VE];

  always_comb begin
    nf = fsc_q;
    nf[`FSQS_B_SIGNALING_NAN_INVALID_FLAG] = fsc_q[`FSQS_B_SIGNALING_NAN_INVALID_FLAG] | snan_q;
    nf[`FSQS_B_INF_MINUS_INF_FLAG] = fsc_q[`FSQS_B_INF_MINUS_INF_FLAG] | isi_q;
    nf[`FSQS_B_INVALID_ROOT_FLAG] = fsc_q[`FSQS_B_INVALID_ROOT_FLAG] | sqinv_q;
    nf[`FSQS_B_OX] = fsc_q[`FSQS_B_OX] | (op_sub && !spec_q && rr.ox);
    nf[`FSQS_B_UX] = fsc_q[`FSQS_B_UX] | (op_sub && !spec_q && rr.ux);
    nf[`FSQS_B_XX] = fsc_q[`FSQS_B_XX] | (!spec_q && rr.xx);
    nf[`FSQS_B_FR] = !spec_q && !supp && rr.fr;
    nf[`FSQS_B_FI] = !spec_q && !supp && rr.xx;
    if (!supp) nf[16:12] = result_class(fin_val, op_sgl);
    nf[`FSQS_B_FX] = fsc_q[`FSQS_B_FX] | ((nf & ~fsc_q & `FSQS_EXC_MASK) != 32'h0);
    nf[`FSQS_B_VX] = (nf & `FSQS_VX_MASK) != 32'h0;
    nf[`FSQS_B_FEX] = (nf[29:25] & nf[7:3]) != 5'h00;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fsc_q <= `FSQS_FSC_RST;
    end else if (fin_go) begin
      fsc_q <= nf;
    end else if (ce && acc && avs_write && (avs_address == `FSQS_REG_FSC)) begin
      fsc_q <= be_merge(fsc_q, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_q <= 64'h0;
      wrote_q <= 1'b0;
      cond_q <= 4'h0;
      op_done <= 1'b0;
    end else if (ce) begin
      op_done <= fin_go;
      if (fin_go) begin
        wrote_q <= !supp;
        if (!supp) res_q <= fin_val;
        if (op_rc) cond_q <= nf[31:28];
      end
    end
  end

  // Illegal encodings leave every result untouched; the sticky flag wins over a clear.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ill_q <= 1'b0;
      illegal_insn <= 1'b0;
    end else if (ce) begin
      illegal_insn <= (st_q == fsqs_pkg::FSQS_PREP) && !op_valid;
      if ((st_q == fsqs_pkg::FSQS_PREP) && !op_valid) begin
        ill_q <= 1'b1;
      end else if (acc && avs_write && (avs_address == `FSQS_REG_STAT) &&
                   avs_byteenable[0] && avs_writedata[`FSQS_ST_ILL]) begin
        ill_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  root_inv_a: assert property (fin_go && op_root && sqinv_q |=> fsc_q[`FSQS_B_INVALID_ROOT_FLAG])
    else $error("negative root did not flag invalid root");
  trap_hold_a: assert property (fin_go && supp |=> $stable(res_q) && !wrote_q)
    else $error("destination written under invalid trap");
  class_hold_a: assert property (fin_go && supp |=> $stable(fsc_q[16:12]))
    else $error("result class changed under invalid trap");
  cond_copy_a: assert property (fin_go && op_rc |=> cond_q == fsc_q[31:28])
    else $error("condition field not copied");
  cond_keep_a: assert property (fin_go && !op_rc |=> $stable(cond_q))
    else $error("condition field changed without record bit");
  root_flag_a: assert property (fin_go && op_root |=> $stable(fsc_q[28:26]))
    else $error("root changed overflow or underflow");
  sub_self_a: assert property (fin_go && op_sub && (opa_q == opb_q) && !a_nan && !a_inf
                               && !supp |=> res_q[62:0] == 63'h0)
    else $error("x minus x not zero");
  sgl_round_a: assert property (fin_go && op_sgl && !supp |=> res_q[28:0] == 29'h0)
    else $error("single result carries double bits");
  root_steps_a: assert property (st_q == fsqs_pkg::FSQS_ROOT |-> iter_q <= `FSQS_ROOT_LAST)
    else $error("root iteration overran");
  root_norm_a: assert property (fin_go && op_root && !spec_q |-> sig_q[63])
    else $error("root significand not normalized");
  illegal_a: assert property ((st_q == fsqs_pkg::FSQS_PREP) && ce && !op_valid
                              |=> ill_q && illegal_insn && (st_q == fsqs_pkg::FSQS_IDLE))
    else $error("illegal encoding not flagged");

  root_done_c: cover property (fin_go && op_root && !spec_q);
  sub_inexact_c: cover property (fin_go && op_sub && !spec_q && rr.xx);
  trap_supp_c: cover property (fin_go && supp);
endmodule : fsqs_unit
`default_nettype wire

// [tb/fsqs_host_model.sv]
// Purpose: Avalon-MM master standing in for the dispatch side of the unit.
// Assumes: One access at a time, word addressing, all byte lanes on.
// Notes: Each request is held until waitrequest is sampled low.
`timescale 1ns/100ps
`default_nettype none
module fsqs_host_model (
  input wire logic core_clk,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  // ==========================================================
  // Bus cycles
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : bus_write
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read
endmodule : fsqs_host_model
`default_nettype wire

// [tb/fsqs_unit_tb.sv]
// Purpose: Self-checking bench of the root and subtract unit.
// Assumes: Results are read back over the register bus.
// Notes: Expected words are worked out by hand from the operands.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fsqs_unit_tb;
  logic core_clk;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic op_done;
  logic illegal_insn;
  logic [31:0] rd;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int dones = 0;
  int ills = 0;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  fsqs_unit i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_done(op_done), .illegal_insn(illegal_insn));
  fsqs_host_model i_host (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // ==========================================================
  // Pulse counting and hang limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (op_done === 1'b1) dones <= dones + 1;
    if (illegal_insn === 1'b1) ills <= ills + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // ==========================================================
  // Operation helpers
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    i_host.bus_read(a, rd);
    `CHK(rd, e)
  endtask : rd_chk
  task automatic op(input logic [63:0] a, input logic [63:0] b, input logic [31:0] insn,
      input logic [31:0] fsc);
    i_host.bus_write(4'h5, fsc);
    i_host.bus_write(4'h0, a[31:0]);
    i_host.bus_write(4'h1, a[63:32]);
    i_host.bus_write(4'h2, b[31:0]);
    i_host.bus_write(4'h3, b[63:32]);
    i_host.bus_write(4'h4, insn);
  endtask : op
  task automatic res(input logic [63:0] r, input logic [31:0] fsc);
    rd_chk(4'h6, r[31:0]);
    rd_chk(4'h7, r[63:32]);
    rd_chk(4'h5, fsc);
  endtask : res
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(4'h5, 32'h0000_0000);
    rd_chk(4'h8, 32'h0000_0000);
    op(64'h4008_0000_0000_0000, 64'h3ff0_0000_0000_0000, 32'hfc00_0028, 32'h0);
    res(64'h4000_0000_0000_0000, 32'h0000_4000);
    op(64'h3ff0_0000_0000_0000, 64'h4008_0000_0000_0000, 32'hfc00_0029, 32'h0);
    res(64'hc000_0000_0000_0000, 32'h0000_8000);
    rd_chk(4'h8, 32'h0000_0010);
    op(64'h0, 64'h4010_0000_0000_0000, 32'hfc00_002c, 32'h0);
    // Clock enable low must freeze the root, so no completion may appear meanwhile.
    ce <= 1'b0;
    repeat (70) @(posedge core_clk);
    `CHK(dones, 2)
    ce <= 1'b1;
    res(64'h4000_0000_0000_0000, 32'h0000_4000);
    op(64'h0, 64'h4000_0000_0000_0000, 32'hec00_002c, 32'h0);
    res(64'h3ff6_a09e_6000_0000, 32'h8202_4000);
    op(64'h0, 64'h4000_0000_0000_0000, 32'hec00_002c, 32'h2);
    res(64'h3ff6_a09e_8000_0000, 32'h8206_4002);
    op(64'h3ff0_0000_0000_0000, 64'h3e10_0000_0000_0000, 32'hec00_0028, 32'h0);
    res(64'h3ff0_0000_0000_0000, 32'h8206_4000);
    // The trapped root must leave the previous, different result in place.
    op(64'h0, 64'hc010_0000_0000_0000, 32'hfc00_002d, 32'h80);
    res(64'h3ff0_0000_0000_0000, 32'he000_0280);
    rd_chk(4'h8, 32'h0000_000e);
    op(64'h0, 64'hc010_0000_0000_0000, 32'hfc00_002c, 32'h0);
    res(64'h7ff8_0000_0000_0000, 32'ha001_1200);
    rd_chk(4'h8, 32'h0000_001e);
    op(64'h7ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, 32'hfc00_0028, 32'h0);
    res(64'h7ff8_0000_0000_0000, 32'ha081_1000);
    rd_chk(4'h8, 32'h0000_001e);
    op(64'h0, 64'h7ff4_0000_0000_0000, 32'hfc00_002c, 32'h0);
    res(64'h7ffc_0000_0000_0000, 32'ha101_1000);
    op(64'h0, 64'h8000_0000_0000_0000, 32'hfc00_002c, 32'h0);
    res(64'h8000_0000_0000_0000, 32'h0001_2000);
    op(64'h4008_0000_0000_0000, 64'h4008_0000_0000_0000, 32'hfc00_0028, 32'h3);
    res(64'h8000_0000_0000_0000, 32'h0001_2003);
    i_host.bus_write(4'h4, 32'hfc00_002a);
    rd_chk(4'h8, 32'h0000_003e);
    i_host.bus_write(4'h8, 32'h0000_0020);
    rd_chk(4'h8, 32'h0000_001e);
    i_host.bus_write(4'h9, 32'hffff_ffff);
    rd_chk(4'h9, 32'h0000_0000);
    `CHK(dones, 12)
    `CHK(ills, 1)
    test_done();
  end
endmodule : fsqs_unit_tb
`default_nettype wire
